// ==== rtl/cpu_status_defs.svh ====
// Offsets, field positions, reset values and timing counts of the status block
`ifndef CPU_STATUS_DEFS_SVH
`define CPU_STATUS_DEFS_SVH
`define OFS_ACC 8'h00
`define OFS_PROG_CNT 8'h04
`define OFS_CMD 8'h08
`define OFS_STAT 8'h0c
`define OFS_DADDR 8'h10
`define OFS_DATA 8'h14
`define OFS_STATUS_WORD 8'hd0
`define SFR_BASE 8'h80
`define SFR_STATUS_WORD 8'hd0
`define SFR_ACC 8'he0
`define CARRY_FLAG_BIT 7
`define AUX_CARRY_FLAG_BIT 6
`define USER_FLAG_ZERO_BIT 5
`define BANK_SELECT_HIGH_BIT 4
`define BANK_SELECT_LOW_BIT 3
`define OVERFLOW_FLAG_BIT 2
`define USER_FLAG_ONE_BIT 1
`define PARITY_BIT 0
`define CMD_OP_LSB 0
`define CMD_OPERAND_LSB 8
`define DADDR_SPACE_LSB 16
`define STAT_BUSY_BIT 0
`define STAT_FETCH_EXT_BIT 1
`define STAT_SELECT_BIT 2
`define STAT_BANK_LSB 3
`define STAT_DERR_BIT 5
`define STATUS_WORD_RST 8'h00
`define ACC_RST 8'h00
`define PROG_CNT_RST 16'h0000
`define FETCH_EXT_RST 1'b0
`define SELECT_RST 1'b1
`define ONCHIP_PROG_TOP 16'h8000
`define IRAM_BYTES 256
`define EXT_RAM_BYTES 1024
`define BANK_BYTES 8
`define CLK_PERIOD_PS 8000
`define MC_TIME_NS 500
`define MC_CYCLES ((`MC_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== rtl/cpu_status_pkg.sv ====
// Types shared by the status and fetch-space block
package cpu_status_pkg;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;
  typedef struct packed {
    logic strobe;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ext_data_s;
  typedef enum logic [2:0] {
    OP_NOP = 3'b000, OP_ADD = 3'b001, OP_ADDC = 3'b010, OP_SUBB = 3'b011,
    OP_DA = 3'b100, OP_MOV = 3'b101
  } alu_op_e;
  typedef enum logic [2:0] {
    SP_DIRECT = 3'b000, SP_INDIRECT = 3'b001, SP_EXT_RAM = 3'b010,
    SP_WREG = 3'b011, SP_XDATA = 3'b100
  } space_e;
  typedef enum logic [2:0] {
    TG_NONE = 3'b000, TG_IRAM = 3'b001, TG_EXT_RAM = 3'b010, TG_SW = 3'b011,
    TG_ACC = 3'b100, TG_EXT = 3'b101
  } target_e;
  typedef enum logic {EX_IDLE = 1'b0, EX_WAIT = 1'b1} exec_e;
endpackage

// ==== rtl/input_sync3.sv ====
// Three-flop pin synchroniser that moves once the last two stages agree
`timescale 1ns/10ps
module input_sync3 #(
  parameter logic INIT = 1'b0
) (
  input logic clk,
  input logic rst_n,
  input logic async_in,
  output logic level_r
);
  logic s1_r, s2_r, s3_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      level_r <= INIT;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule // input_sync3

// ==== rtl/status_alu.sv ====
// Accumulator arithmetic with carry, auxiliary carry and overflow results
`timescale 1ns/10ps
module status_alu (
  input cpu_status_pkg::alu_op_e op,
  input logic [7:0] acc_in,
  input logic [7:0] operand,
  input logic carry_in,
  input logic aux_in,
  input logic ovf_in,
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic aux_out,
  output logic ovf_out
);
  import cpu_status_pkg::*;
  logic [8:0] full, adj;
  logic [7:0] low7;
  logic [4:0] low4;
  logic cin, cy_da;

  always_comb begin
    cin = (op == OP_ADDC || op == OP_SUBB) ? carry_in : 1'b0;
    acc_out = acc_in;
    carry_out = carry_in;
    aux_out = aux_in;
    ovf_out = ovf_in;
    full = 9'h000;
    low7 = 8'h00;
    low4 = 5'h00;
    adj = 9'h000;
    cy_da = 1'b0;
    unique case (op)
      OP_ADD, OP_ADDC: begin
        full = {1'b0, acc_in} + {1'b0, operand} + {8'h00, cin};
        low7 = {1'b0, acc_in[6:0]} + {1'b0, operand[6:0]} + {7'h00, cin};
        low4 = {1'b0, acc_in[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
      end
      OP_SUBB: begin
        full = {1'b0, acc_in} - {1'b0, operand} - {8'h00, cin};
        low7 = {1'b0, acc_in[6:0]} - {1'b0, operand[6:0]} - {7'h00, cin};
        low4 = {1'b0, acc_in[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
      end
      default: ;
    endcase
    unique case (op)
      OP_ADD, OP_ADDC, OP_SUBB: begin
        acc_out = full[7:0];
        carry_out = full[8];
        aux_out = low4[4];
        ovf_out = full[8] ^ low7[7];
      end
      OP_DA: begin
        adj = {1'b0, acc_in};
        if (acc_in[3:0] > 4'h9 || aux_in) adj = adj + 9'h006;
        cy_da = carry_in | adj[8];
        if (adj[7:4] > 4'h9 || cy_da) adj = {1'b0, adj[7:0]} + 9'h060;
        acc_out = adj[7:0];
        carry_out = cy_da | adj[8];
      end
      OP_MOV: acc_out = operand;
      default: ;
    endcase
  end
endmodule // status_alu

// ==== rtl/cpu_status_fetch_space.sv ====
// Program status word, fetch routing and address spaces behind an AXI4-Lite slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`include "cpu_status_defs.svh"
// Function
// - Select high: fetch on-chip while counter below 8000h
// - Select low: every fetch goes external
// - Bank bits pick register bank base address
// - Parity follows accumulator one-bit count after instructions
// - Status word at D0, fixed bit order
// - Arithmetic sets carry, overflow; BCD uses aux carry
// - 64K program space, 32K on-chip
// - Separate 64K external data space addressed
// - 256-byte internal data holds four banks
// - Separate 1K extended data RAM
// - 128-byte special register area decoded separately
// - Instruction completes within one 500 ns cycle
module cpu_status_fetch_space (
  input logic REF_CLK,
  input logic RST_N,
  input cpu_status_pkg::axil_req_s AXI_REQ,
  output cpu_status_pkg::axil_rsp_s AXI_RSP,
  input logic EXT_FETCH_SELECT,
  output logic FETCH_EXTERNAL,
  output logic [15:0] PROGRAM_COUNTER,
  output logic [1:0] ACTIVE_BANK,
  output cpu_status_pkg::ext_data_s EXT_DATA
);
  import cpu_status_pkg::*;
  localparam logic [5:0] MC_LAST = 6'(`MC_CYCLES - 1);

  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:1] sw_r;
  logic [7:0] acc_r;
  logic [15:0] program_counter_r;
  exec_e exec_r;
  alu_op_e op_r;
  logic [7:0] operand_r;
  logic [5:0] mc_cnt_r;
  logic [15:0] daddr_r;
  space_e dspace_r;
  logic derr_r;
  logic [7:0] iram_r [`IRAM_BYTES];
  logic [7:0] ext_ram_r [`EXT_RAM_BYTES];
  logic external_fetch_select;
  logic fetch_ext_r;
  ext_data_s ext_r;
  logic [7:0] status_word, alu_acc, tgt_rd, iram_idx;
  logic [9:0] ext_ram_idx;
  logic [1:0] bank;
  logic alu_cy, alu_aux, alu_ovf;
  logic mc_tick, retire, wr_go, ar_go, wr_ok, d_err, rd_err;
  logic sw_we, acc_we, data_we;
  logic [31:0] wd, rd_val;
  target_e tgt;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[8*i +: 8] = nw[8*i +: 8];
    end
    return m;
  endfunction
  input_sync3 #(.INIT(`SELECT_RST)) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .async_in(EXT_FETCH_SELECT),
    .level_r(external_fetch_select)
  );
  status_alu u_alu (
    .op(op_r),
    .acc_in(acc_r),
    .operand(operand_r),
    .carry_in(sw_r[`CARRY_FLAG_BIT]),
    .aux_in(sw_r[`AUX_CARRY_FLAG_BIT]),
    .ovf_in(sw_r[`OVERFLOW_FLAG_BIT]),
    .acc_out(alu_acc),
    .carry_out(alu_cy),
    .aux_out(alu_aux),
    .ovf_out(alu_ovf)
  );
  // Parity is always the odd-count of accumulator ones, so it is never stale
  assign status_word = {sw_r, ^acc_r};
  assign bank = sw_r[`BANK_SELECT_HIGH_BIT:`BANK_SELECT_LOW_BIT];
  assign mc_tick = (mc_cnt_r == MC_LAST);
  assign retire = (exec_r == EX_WAIT) && mc_tick;
  // Writes wait one cycle when an instruction retires, so flags never collide
  assign wr_go = aw_held_r && w_held_r && !bvalid_r && !retire;
  assign ar_go = AXI_REQ.arvalid && !rvalid_r;
  assign wd = merge(32'h0000_0000, wdata_r, wstrb_r);
  assign AXI_RSP.awready = !aw_held_r;
  assign AXI_RSP.wready = !w_held_r;
  assign AXI_RSP.bvalid = bvalid_r;
  assign AXI_RSP.bresp = bresp_r;
  assign AXI_RSP.arready = !rvalid_r;
  assign AXI_RSP.rvalid = rvalid_r;
  assign AXI_RSP.rdata = rdata_r;
  assign AXI_RSP.rresp = rresp_r;
  assign FETCH_EXTERNAL = fetch_ext_r;
  assign PROGRAM_COUNTER = program_counter_r;
  assign ACTIVE_BANK = sw_r[`BANK_SELECT_HIGH_BIT:`BANK_SELECT_LOW_BIT];
  assign EXT_DATA = ext_r;
  // Data window decode over the five operand spaces
  always_comb begin
    tgt = TG_NONE;
    d_err = 1'b0;
    iram_idx = daddr_r[7:0];
    ext_ram_idx = daddr_r[9:0];
    unique case (dspace_r)
      SP_DIRECT: begin
        if (daddr_r[15:8] != 8'h00) begin
          d_err = 1'b1;
        end else if (daddr_r[7:0] < `SFR_BASE) begin
          tgt = TG_IRAM;
        end else if (daddr_r[7:0] == `SFR_STATUS_WORD) begin
          tgt = TG_SW;
        end else if (daddr_r[7:0] == `SFR_ACC) begin
          tgt = TG_ACC;
        end
      end
      SP_INDIRECT: begin
        if (daddr_r[15:8] != 8'h00) d_err = 1'b1;
        else tgt = TG_IRAM;
      end
      SP_EXT_RAM: begin
        if (daddr_r >= 16'(`EXT_RAM_BYTES)) d_err = 1'b1;
        else tgt = TG_EXT_RAM;
      end
      SP_WREG: begin
        if (daddr_r >= 16'(`BANK_BYTES)) begin
          d_err = 1'b1;
        end else begin
          tgt = TG_IRAM;
          iram_idx = {3'b000, bank, daddr_r[2:0]};
        end
      end
      SP_XDATA: tgt = TG_EXT;
      default: d_err = 1'b1;
    endcase
  end

  always_comb begin
    unique case (tgt)
      TG_IRAM: tgt_rd = iram_r[iram_idx];
      TG_EXT_RAM: tgt_rd = ext_ram_r[ext_ram_idx];
      TG_SW: tgt_rd = status_word;
      TG_ACC: tgt_rd = acc_r;
      default: tgt_rd = 8'h00;
    endcase
  end

  always_comb begin
    unique case (awaddr_r)
      `OFS_ACC, `OFS_PROG_CNT, `OFS_STAT, `OFS_DADDR, `OFS_STATUS_WORD: wr_ok = 1'b1;
      `OFS_CMD: wr_ok = (exec_r == EX_IDLE);
      `OFS_DATA: wr_ok = !d_err;
      default: wr_ok = 1'b0;
    endcase
  end

  assign data_we = wr_go && (awaddr_r == `OFS_DATA) && !d_err && wstrb_r[0];
  assign sw_we = (wr_go && (awaddr_r == `OFS_STATUS_WORD) && wstrb_r[0])
                 || (data_we && tgt == TG_SW);
  assign acc_we = (wr_go && (awaddr_r == `OFS_ACC) && wstrb_r[0])
                  || (data_we && tgt == TG_ACC);

  always_comb begin
    rd_err = 1'b0;
    rd_val = 32'h0000_0000;
    unique case (AXI_REQ.araddr)
      `OFS_ACC: rd_val[7:0] = acc_r;
      `OFS_PROG_CNT: rd_val[15:0] = program_counter_r;
      `OFS_CMD: begin
        rd_val[`CMD_OP_LSB +: 3] = op_r;
        rd_val[`CMD_OPERAND_LSB +: 8] = operand_r;
      end
      `OFS_STAT: begin
        rd_val[`STAT_BUSY_BIT] = (exec_r == EX_WAIT);
        rd_val[`STAT_FETCH_EXT_BIT] = fetch_ext_r;
        rd_val[`STAT_SELECT_BIT] = external_fetch_select;
        rd_val[`STAT_BANK_LSB +: 2] = bank;
        rd_val[`STAT_DERR_BIT] = derr_r;
      end
      `OFS_DADDR: begin
        rd_val[15:0] = daddr_r;
        rd_val[`DADDR_SPACE_LSB +: 3] = dspace_r;
      end
      `OFS_DATA: begin
        rd_val[7:0] = tgt_rd;
        rd_err = d_err;
      end
      `OFS_STATUS_WORD: rd_val[7:0] = status_word;
      default: rd_err = 1'b1;
    endcase
  end
  // Write address and write data are captured independently
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (AXI_REQ.awvalid && !aw_held_r) begin
      aw_held_r <= 1'b1;
      awaddr_r <= AXI_REQ.awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (AXI_REQ.wvalid && !w_held_r) begin
      w_held_r <= 1'b1;
      wdata_r <= AXI_REQ.wdata;
      wstrb_r <= AXI_REQ.wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (AXI_REQ.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (ar_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_err ? 32'h0000_0000 : rd_val;
      rresp_r <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (AXI_REQ.rready) begin
      rvalid_r <= 1'b0;
    end
  end
  // Machine-cycle timebase; a pending instruction retires on its last count
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      mc_cnt_r <= 6'h00;
    end else if (mc_tick) begin
      mc_cnt_r <= 6'h00;
    end else begin
      mc_cnt_r <= mc_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      exec_r <= EX_IDLE;
      op_r <= OP_NOP;
      operand_r <= 8'h00;
    end else if (retire) begin
      exec_r <= EX_IDLE;
    end else if (wr_go && awaddr_r == `OFS_CMD && exec_r == EX_IDLE && wstrb_r[0]) begin
      exec_r <= EX_WAIT;
      op_r <= alu_op_e'(wd[`CMD_OP_LSB +: 3]);
      if (wstrb_r[1]) operand_r <= wd[`CMD_OPERAND_LSB +: 8];
    end
  end
  // User flags and bank bits change only by software writes
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sw_r <= 7'(`STATUS_WORD_RST >> 1);
    end else if (retire) begin
      sw_r[`CARRY_FLAG_BIT] <= alu_cy;
      sw_r[`AUX_CARRY_FLAG_BIT] <= alu_aux;
      sw_r[`OVERFLOW_FLAG_BIT] <= alu_ovf;
    end else if (sw_we) begin
      sw_r <= wd[7:1];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      acc_r <= `ACC_RST;
    end else if (retire) begin
      acc_r <= alu_acc;
    end else if (acc_we) begin
      acc_r <= wd[7:0];
    end
  end
  // Program counter spans the full 64K program space
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      program_counter_r <= `PROG_CNT_RST;
    end else if (retire) begin
      program_counter_r <= program_counter_r + 16'h0001;
    end else if (wr_go && awaddr_r == `OFS_PROG_CNT) begin
      program_counter_r <= 16'(merge({16'h0000, program_counter_r}, wdata_r, wstrb_r));
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      fetch_ext_r <= `FETCH_EXT_RST;
    end else begin
      fetch_ext_r <= !external_fetch_select
                     || (program_counter_r >= `ONCHIP_PROG_TOP);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      daddr_r <= 16'h0000;
      dspace_r <= SP_DIRECT;
    end else if (wr_go && awaddr_r == `OFS_DADDR) begin
      if (wstrb_r[0]) daddr_r[7:0] <= wd[7:0];
      if (wstrb_r[1]) daddr_r[15:8] <= wd[15:8];
      if (wstrb_r[2]) dspace_r <= space_e'(wd[`DADDR_SPACE_LSB +: 3]);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      derr_r <= 1'b0;
    end else if (wr_go && awaddr_r == `OFS_DATA) begin
      derr_r <= d_err;
    end else if (ar_go && AXI_REQ.araddr == `OFS_DATA) begin
      derr_r <= d_err;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < `IRAM_BYTES; i++) iram_r[i] <= 8'h00;
    end else if (data_we && tgt == TG_IRAM) begin
      iram_r[iram_idx] <= wd[7:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < `EXT_RAM_BYTES; i++) ext_ram_r[i] <= 8'h00;
    end else if (data_we && tgt == TG_EXT_RAM) begin
      ext_ram_r[ext_ram_idx] <= wd[7:0];
    end
  end
  // External data space is only addressed here; a write wins a same-cycle read
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ext_r <= '0;
    end else if (data_we && tgt == TG_EXT) begin
      ext_r <= '{strobe: 1'b1, write: 1'b1, addr: daddr_r, wdata: wd[7:0]};
    end else if (ar_go && AXI_REQ.araddr == `OFS_DATA && tgt == TG_EXT) begin
      ext_r <= '{strobe: 1'b1, write: 1'b0, addr: daddr_r, wdata: 8'h00};
    end else begin
      ext_r.strobe <= 1'b0;
    end
  end
endmodule // cpu_status_fetch_space

// ==== verif/cpu_status_fetch_space_properties.sv ====
// Port-level assertions for the status and fetch-space block
`timescale 1ns/10ps
module cpu_status_fetch_space_properties (
  input logic REF_CLK,
  input logic RST_N,
  input cpu_status_pkg::axil_req_s AXI_REQ,
  input cpu_status_pkg::axil_rsp_s AXI_RSP,
  input logic EXT_FETCH_SELECT,
  input logic FETCH_EXTERNAL,
  input logic [15:0] PROGRAM_COUNTER,
  input logic [1:0] ACTIVE_BANK,
  input cpu_status_pkg::ext_data_s EXT_DATA
);
  import cpu_status_pkg::*;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  a_reset_idle: assert property (disable iff (1'b0)
    !RST_N |=> !AXI_RSP.bvalid && !AXI_RSP.rvalid && ACTIVE_BANK == 2'b00)
    else $error("outputs not idle after reset");
  a_sel_low_ext: assert property (
    !EXT_FETCH_SELECT [*6] |=> FETCH_EXTERNAL) else $error("low select fetched on-chip");
  a_onchip_fetch: assert property (
    (EXT_FETCH_SELECT && PROGRAM_COUNTER < 16'h8000) [*6] |=> !FETCH_EXTERNAL)
    else $error("low counter fetched external");
  a_pc_high_ext: assert property (
    PROGRAM_COUNTER >= 16'h8000 |=> FETCH_EXTERNAL) else $error("high counter fetched on-chip");
  a_read_answer: assert property (
    AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid) else $error("read not answered");
  a_write_answer: assert property (
    AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready
    |-> ##[2:3] AXI_RSP.bvalid) else $error("write not answered");
  a_rdata_hold: assert property (
    AXI_RSP.rvalid && !AXI_REQ.rready |=> AXI_RSP.rvalid && $stable(AXI_RSP.rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (
    AXI_RSP.bvalid && !AXI_REQ.bready |=> AXI_RSP.bvalid && $stable(AXI_RSP.bresp))
    else $error("write response dropped");
  a_strobe_pulse: assert property (
    EXT_DATA.strobe |=> !EXT_DATA.strobe) else $error("strobe longer than one cycle");
  c_write: cover property (AXI_RSP.bvalid && AXI_REQ.bready);
  c_ext_write: cover property (EXT_DATA.strobe && EXT_DATA.write);
  c_fetch_ext: cover property ($rose(FETCH_EXTERNAL));
endmodule // cpu_status_fetch_space_properties

bind cpu_status_fetch_space cpu_status_fetch_space_properties props_u (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .EXT_FETCH_SELECT(EXT_FETCH_SELECT),
  .FETCH_EXTERNAL(FETCH_EXTERNAL), .PROGRAM_COUNTER(PROGRAM_COUNTER),
  .ACTIVE_BANK(ACTIVE_BANK), .EXT_DATA(EXT_DATA));

// ==== verif/ext_data_model.sv ====
// External data memory model that records strobed writes
`timescale 1ns/10ps
module ext_data_model (
  input logic clk,
  input logic rst_n,
  input cpu_status_pkg::ext_data_s ext,
  output logic [15:0] last_addr,
  output logic [7:0] last_data,
  output logic [7:0] write_count
);
  import cpu_status_pkg::*;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_addr <= 16'h0000;
      last_data <= 8'h00;
      write_count <= 8'h00;
    end else if (ext.strobe && ext.write) begin
      last_addr <= ext.addr;
      last_data <= ext.wdata;
      write_count <= write_count + 8'h01;
    end
  end
endmodule // ext_data_model

// ==== verif/test_cpu_status_fetch_space.sv ====
// Self-checking bench for the status and fetch-space block
`timescale 1ns/10ps
module test_cpu_status_fetch_space;
  import cpu_status_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b1;
  axil_req_s req = '0;
  axil_rsp_s rsp;
  ext_data_s ext;
  logic fetch_ext;
  logic [15:0] pc;
  logic [1:0] bank;
  logic [15:0] ext_addr;
  logic [7:0] ext_data;
  logic [7:0] ext_cnt;
  logic [31:0] rdat;
  logic [1:0] resp;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  always @(posedge clk) cyc++;
  cpu_status_fetch_space dut_u (.REF_CLK(clk), .RST_N(rst_n), .AXI_REQ(req), .AXI_RSP(rsp),
    .EXT_FETCH_SELECT(sel), .FETCH_EXTERNAL(fetch_ext), .PROGRAM_COUNTER(pc),
    .ACTIVE_BANK(bank), .EXT_DATA(ext));
  ext_data_model mem_u (.clk(clk), .rst_n(rst_n), .ext(ext), .last_addr(ext_addr),
    .last_data(ext_data), .write_count(ext_cnt));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rdat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  task automatic exec(input alu_op_e op, input logic [7:0] v);
    int t0;
    t0 = cyc;
    wr(8'h08, {16'h0000, v, 5'h00, op});
    do rd(8'h0c); while (rdat[0] !== 1'b0 && cyc - t0 < 300);
    chk(32'(cyc - t0 <= 80), 32'h1);
  endtask
  task automatic t_reset;
    rd_chk(8'hd0, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h00, 32'h0);
    $display("test reset values done");
  endtask
  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, 32'h22 | 32'(b << 3));
      rd_chk(8'hd0, 32'h22 | 32'(b << 3));
      chk(32'(bank), 32'(b));
      wr(8'h10, 32'h30007);
      wr(8'h14, 32'h40 + 32'(b));
      wr(8'h10, 32'h10007 + 32'(b * 8));
      rd_chk(8'h14, 32'h40 + 32'(b));
    end
    wr(8'h10, 32'h100ff);
    wr(8'h14, 32'ha5);
    rd_chk(8'h14, 32'ha5);
    $display("test register banks done");
  endtask
  task automatic t_arith;
    wr(8'hd0, 32'h0);
    wr(8'h00, 32'hff);
    exec(OP_ADD, 8'h01);
    rd_chk(8'hd0, 32'hc0);
    wr(8'h00, 32'h7f);
    exec(OP_ADD, 8'h01);
    rd_chk(8'hd0, 32'h45);
    exec(OP_MOV, 8'h03);
    rd_chk(8'hd0, 32'h44);
    exec(OP_MOV, 8'h07);
    rd_chk(8'hd0, 32'h45);
    rd_chk(8'h00, 32'h07);
    wr(8'hd0, 32'h80);
    exec(OP_ADDC, 8'h08);
    rd_chk(8'hd0, 32'h41);
    exec(OP_DA, 8'h00);
    rd_chk(8'h00, 32'h16);
    exec(OP_SUBB, 8'h17);
    rd_chk(8'hd0, 32'hc0);
    exec(OP_NOP, 8'h00);
    rd_chk(8'hd0, 32'hc0);
    chk(32'(pc), 32'h8);
    $display("test arithmetic flags done");
  endtask
  task automatic t_fetch;
    wr(8'h04, 32'h7fff);
    repeat (3) @(posedge clk);
    chk(32'(fetch_ext), 32'h0);
    wr(8'h04, 32'h8000);
    repeat (3) @(posedge clk);
    chk(32'(fetch_ext), 32'h1);
    wr(8'h04, 32'hffff);
    rd_chk(8'h04, 32'hffff);
    wr(8'h04, 32'h0);
    sel <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(fetch_ext), 32'h1);
    sel <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(fetch_ext), 32'h0);
    $display("test fetch select done");
  endtask
  task automatic t_spaces;
    wr(8'h10, 32'h4beef);
    wr(8'h14, 32'h5a);
    @(posedge clk);
    chk({ext_cnt, ext_data, ext_addr}, 32'h015abeef);
    wr(8'h10, 32'h203ff);
    wr(8'h14, 32'h3c);
    rd_chk(8'h14, 32'h3c);
    wr(8'h10, 32'h20400);
    wr(8'h14, 32'h1);
    chk(32'(resp), 32'h2);
    wr(8'h10, 32'h000d0);
    rd_chk(8'h14, 32'hc0);
    wr(8'h10, 32'h000e0);
    rd_chk(8'h14, 32'hff);
    wr(8'h10, 32'h00080);
    rd_chk(8'h14, 32'h0);
    rd(8'h18);
    chk(32'(resp), 32'h2);
    $display("test address spaces done");
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_banks();
    t_arith();
    t_fetch();
    t_spaces();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule // test_cpu_status_fetch_space
